//--- rtl/uart_shadow_control_regs.sv
// Shadow control register group of a serial port, reached over APB
//
// Summary of operation
// - break mirror bit 0 reads/writes break
// - break mirror only with shadow option
// - DMA mode mirror bit 0 tracks control bit 3
// - FIFO enable mirror tracks control bit 0
// - FIFO mirrors need FIFO and shadow option
// - receive trigger mirror bits 1:0, reset 00
// - receive trigger: one, quarter, half, two short
// - transmit trigger mirror needs three options
// - transmit trigger 00 empty, 01 two left
// - transmit trigger 10 quarter, 11 half
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_control_regs
    import shadow_regs_pkg::*;
#(
    parameter bit SHADOW_EN           = 1'b1,
    parameter bit FIFO_PRESENT        = 1'b1,
    parameter bit TX_THRESHOLD_OPTION = 1'b1
)
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Direct writes of the original control words
    input  wire logic              line_control_wr,
    input  wire logic [7:0]        line_control_wdata,
    input  wire logic              fifo_control_wr,
    input  wire logic [7:0]        fifo_control_wdata,
    // FIFO levels from the data path
    input  wire logic [LEVEL_W-1:0] rx_fifo_level,
    input  wire logic [LEVEL_W-1:0] tx_fifo_level,
    // Control outputs
    output logic                   break_ctrl,
    output logic                   dma_mode,
    output logic                   fifo_enable,
    output logic      [TRIG_W-1:0] rx_trigger_sel,
    output logic      [TRIG_W-1:0] tx_trigger_sel,
    output logic                   fifo_flush,
    output logic                   rx_trigger_hit,
    output logic                   tx_threshold_hit
);

    // Presence of each mirror follows the build options
    localparam bit BRK_PRESENT  = SHADOW_EN;
    localparam bit FIFO_MIRRORS = SHADOW_EN && FIFO_PRESENT;
    localparam bit TX_PRESENT   = SHADOW_EN && FIFO_PRESENT && TX_THRESHOLD_OPTION;

    // Bus state
    bus_state_t        state_ff;
    bus_state_t        nxt_state;
    logic              pready_ff;
    logic              nxt_pready;
    logic              pslverr_ff;
    logic              nxt_pslverr;
    logic [DATA_W-1:0] prdata_ff;
    logic [DATA_W-1:0] nxt_prdata;

    // Control state, shared by both views so they cannot drift apart
    logic              break_ff;
    logic              nxt_break;
    logic              dma_mode_ff;
    logic              nxt_dma_mode;
    logic              fifo_en_ff;
    logic              nxt_fifo_en;
    logic [TRIG_W-1:0] rx_trig_ff;
    logic [TRIG_W-1:0] nxt_rx_trig;
    logic [TRIG_W-1:0] tx_trig_ff;
    logic [TRIG_W-1:0] nxt_tx_trig;
    logic              flush_ff;
    logic              nxt_flush;
    logic              rx_hit_ff;
    logic              nxt_rx_hit;
    logic              tx_hit_ff;
    logic              nxt_tx_hit;

    // Decode
    logic              addr_ok;
    logic [DATA_W-1:0] rd_word;
    logic              wr_take;
    logic              rx_hit_raw;
    logic              tx_hit_raw;

    always_comb
    begin
        addr_ok = 1'b0;
        rd_word = '0;
        case (paddr)
            OFS_BREAK_MIRROR:
            begin
                addr_ok = BRK_PRESENT;
                rd_word[MIRROR_BIT_LSB] = break_ff & BRK_PRESENT;
            end
            OFS_DMA_MODE_MIRROR:
            begin
                addr_ok = FIFO_MIRRORS;
                rd_word[MIRROR_BIT_LSB] = dma_mode_ff & FIFO_MIRRORS;
            end
            OFS_FIFO_EN_MIRROR:
            begin
                addr_ok = FIFO_MIRRORS;
                rd_word[MIRROR_BIT_LSB] = fifo_en_ff & FIFO_MIRRORS;
            end
            OFS_RX_TRIG_MIRROR:
            begin
                addr_ok = FIFO_MIRRORS;
                rd_word[TRIG_W-1:0] = rx_trig_ff & {TRIG_W{FIFO_MIRRORS}};
            end
            OFS_TX_TRIG_MIRROR:
            begin
                addr_ok = TX_PRESENT;
                rd_word[TRIG_W-1:0] = tx_trig_ff & {TRIG_W{TX_PRESENT}};
            end
            default:
            begin
                addr_ok = 1'b0;
                rd_word = '0;
            end
        endcase
    end

    // A write lands on the edge at which the master sees pready high
    assign wr_take = (state_ff == ST_ACK) && psel && penable && pwrite && addr_ok;

    // One wait state keeps prdata, pready and pslverr registered
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata  = prdata_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (psel && penable)
                begin
                    nxt_state   = ST_ACK;
                    nxt_pready  = 1'b1;
                    nxt_pslverr = ~addr_ok;
                    nxt_prdata  = (!pwrite && addr_ok) ? rd_word : '0;
                end
            end
            ST_ACK:
            begin
                nxt_state  = ST_IDLE;
                nxt_prdata = '0;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff   <= ST_IDLE;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end
        else
        begin
            state_ff   <= nxt_state;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    // Mirror writes are applied after direct writes, so software's latest bus access wins a tie
    always_comb
    begin
        nxt_break    = break_ff;
        nxt_dma_mode = dma_mode_ff;
        nxt_fifo_en  = fifo_en_ff;
        nxt_rx_trig  = rx_trig_ff;
        nxt_tx_trig  = tx_trig_ff;
        if (line_control_wr)
        begin
            nxt_break = line_control_wdata[LINE_CTRL_BREAK_BIT];
        end
        if (fifo_control_wr)
        begin
            nxt_fifo_en  = fifo_control_wdata[FIFO_CTRL_EN_BIT];
            nxt_dma_mode = fifo_control_wdata[FIFO_CTRL_DMA_BIT];
            nxt_rx_trig  = fifo_control_wdata[FIFO_CTRL_RX_LSB +: TRIG_W];
            nxt_tx_trig  = fifo_control_wdata[FIFO_CTRL_TX_LSB +: TRIG_W];
        end
        if (wr_take)
        begin
            case (paddr)
                OFS_BREAK_MIRROR:    nxt_break    = pwdata[MIRROR_BIT_LSB];
                OFS_DMA_MODE_MIRROR: nxt_dma_mode = pwdata[MIRROR_BIT_LSB];
                OFS_FIFO_EN_MIRROR:  nxt_fifo_en  = pwdata[MIRROR_BIT_LSB];
                OFS_RX_TRIG_MIRROR:  nxt_rx_trig  = pwdata[MIRROR_BIT_LSB +: TRIG_W];
                OFS_TX_TRIG_MIRROR:  nxt_tx_trig  = pwdata[MIRROR_BIT_LSB +: TRIG_W];
                default:             nxt_break    = nxt_break;
            endcase
        end
        // Toggling FIFO enable empties both FIFOs, whichever view did it
        nxt_flush  = (nxt_fifo_en != fifo_en_ff);
        // Thresholds only mean something while the FIFOs are on
        nxt_rx_hit = fifo_en_ff & rx_hit_raw;
        nxt_tx_hit = fifo_en_ff & tx_hit_raw;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            break_ff    <= RST_BREAK;
            dma_mode_ff <= RST_DMA_MODE;
            fifo_en_ff  <= RST_FIFO_EN;
            rx_trig_ff  <= RST_RX_TRIG;
            tx_trig_ff  <= RST_TX_TRIG;
            flush_ff    <= 1'b0;
            rx_hit_ff   <= 1'b0;
            tx_hit_ff   <= 1'b0;
        end
        else
        begin
            break_ff    <= nxt_break;
            dma_mode_ff <= nxt_dma_mode;
            fifo_en_ff  <= nxt_fifo_en;
            rx_trig_ff  <= nxt_rx_trig;
            tx_trig_ff  <= nxt_tx_trig;
            flush_ff    <= nxt_flush;
            rx_hit_ff   <= nxt_rx_hit;
            tx_hit_ff   <= nxt_tx_hit;
        end
    end

    fifo_threshold_decode u_threshold
    (
        .rx_level (rx_fifo_level),
        .tx_level (tx_fifo_level),
        .rx_trig  (rx_trig_ff),
        .tx_trig  (tx_trig_ff),
        .rx_hit   (rx_hit_raw),
        .tx_hit   (tx_hit_raw)
    );

    // Outputs
    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign break_ctrl       = break_ff;
    assign dma_mode         = dma_mode_ff;
    assign fifo_enable      = fifo_en_ff;
    assign rx_trigger_sel   = rx_trig_ff;
    assign tx_trigger_sel   = tx_trig_ff;
    assign fifo_flush       = flush_ff;
    assign rx_trigger_hit   = rx_hit_ff;
    assign tx_threshold_hit = tx_hit_ff;

endmodule // uart_shadow_control_regs
`default_nettype wire

//--- include/shadow_regs_pkg.sv
// Constants and types shared by the serial port shadow control register block
`default_nettype none
package shadow_regs_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_BREAK_MIRROR    = 8'h90;
    localparam logic [ADDR_W-1:0] OFS_DMA_MODE_MIRROR = 8'h94;
    localparam logic [ADDR_W-1:0] OFS_FIFO_EN_MIRROR  = 8'h98;
    localparam logic [ADDR_W-1:0] OFS_RX_TRIG_MIRROR  = 8'h9C;
    localparam logic [ADDR_W-1:0] OFS_TX_TRIG_MIRROR  = 8'hA0;

    // Field positions inside the original control words
    localparam int unsigned LINE_CTRL_BREAK_BIT = 6;
    localparam int unsigned FIFO_CTRL_EN_BIT    = 0;
    localparam int unsigned FIFO_CTRL_DMA_BIT   = 3;
    localparam int unsigned FIFO_CTRL_TX_LSB    = 4;
    localparam int unsigned FIFO_CTRL_RX_LSB    = 6;

    // Field positions inside the mirror registers
    localparam int unsigned MIRROR_BIT_LSB   = 0;
    localparam int unsigned TRIG_W           = 2;

    // Reset values
    localparam logic              RST_BREAK    = 1'b0;
    localparam logic              RST_DMA_MODE = 1'b0;
    localparam logic              RST_FIFO_EN  = 1'b0;
    localparam logic [TRIG_W-1:0] RST_RX_TRIG  = 2'h0;
    localparam logic [TRIG_W-1:0] RST_TX_TRIG  = 2'h0;

    // FIFO geometry
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned LEVEL_W    = 5;

    // Receive trigger encodings
    typedef enum logic [TRIG_W-1:0] {
        RX_TRIG_ONE_CHAR  = 2'h0,
        RX_TRIG_QUARTER   = 2'h1,
        RX_TRIG_HALF      = 2'h2,
        RX_TRIG_TWO_SHORT = 2'h3
    } rx_trig_t;

    // Transmit-empty trigger encodings
    typedef enum logic [TRIG_W-1:0] {
        TX_TRIG_EMPTY     = 2'h0,
        TX_TRIG_TWO_CHARS = 2'h1,
        TX_TRIG_QUARTER   = 2'h2,
        TX_TRIG_HALF      = 2'h3
    } tx_trig_t;

    // Bus slave states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } bus_state_t;

endpackage
`default_nettype wire

//--- rtl/fifo_threshold_decode.sv
// Combinational FIFO level against trigger code comparison
`timescale 1ns/1ps
`default_nettype none
module fifo_threshold_decode
    import shadow_regs_pkg::*;
(
    // Levels
    input  wire logic [LEVEL_W-1:0] rx_level,
    input  wire logic [LEVEL_W-1:0] tx_level,
    // Trigger codes
    input  wire logic [TRIG_W-1:0]  rx_trig,
    input  wire logic [TRIG_W-1:0]  tx_trig,
    // Conditions
    output logic                    rx_hit,
    output logic                    tx_hit
);

    localparam logic [LEVEL_W-1:0] LVL_ONE     = 5'h01;
    localparam logic [LEVEL_W-1:0] LVL_TWO     = 5'h02;
    localparam logic [LEVEL_W-1:0] LVL_QUARTER = LEVEL_W'(FIFO_DEPTH / 4);
    localparam logic [LEVEL_W-1:0] LVL_HALF    = LEVEL_W'(FIFO_DEPTH / 2);
    localparam logic [LEVEL_W-1:0] LVL_SHORT   = LEVEL_W'(FIFO_DEPTH - 2);

    always_comb
    begin
        case (rx_trig)
            RX_TRIG_ONE_CHAR:  rx_hit = (rx_level >= LVL_ONE);
            RX_TRIG_QUARTER:   rx_hit = (rx_level >= LVL_QUARTER);
            RX_TRIG_HALF:      rx_hit = (rx_level >= LVL_HALF);
            RX_TRIG_TWO_SHORT: rx_hit = (rx_level >= LVL_SHORT);
            default:           rx_hit = 1'b0;
        endcase
        case (tx_trig)
            TX_TRIG_EMPTY:     tx_hit = (tx_level == '0);
            TX_TRIG_TWO_CHARS: tx_hit = (tx_level <= LVL_TWO);
            TX_TRIG_QUARTER:   tx_hit = (tx_level <= LVL_QUARTER);
            TX_TRIG_HALF:      tx_hit = (tx_level <= LVL_HALF);
            default:           tx_hit = 1'b0;
        endcase
    end

endmodule // fifo_threshold_decode
`default_nettype wire

//--- tb/uart_shadow_chk.sv
// Port assertions for the shadow control register block
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_chk
    import shadow_regs_pkg::*;
(
    // Clock, reset and bus
    input wire logic              pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata, prdata,
    // Controls
    input wire logic              fifo_control_wr, break_ctrl, dma_mode, fifo_enable, fifo_flush,
    input wire logic              rx_trigger_hit, tx_threshold_hit,
    input wire logic [7:0]        fifo_control_wdata,
    input wire logic [TRIG_W-1:0] rx_trigger_sel
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Absent builds would need this list trimmed
    wire       mapped = paddr inside {8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0};
    wire       wbit   = pwdata[0];
    wire [3:0] fbits  = {fifo_control_wdata[7:6], fifo_control_wdata[3], fifo_control_wdata[0]};
    a_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_absent: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_rsvd_zero: assert property (pready |-> prdata[31:2] == 30'h0)
        else $error("reserved bits not zero");
    a_break_read: assert property (pready && !pwrite && paddr == OFS_BREAK_MIRROR |-> prdata == {31'h0, break_ctrl})
        else $error("break read differs from break state");
    a_break_write: assert property (pready && pwrite && paddr == OFS_BREAK_MIRROR |=> break_ctrl == $past(wbit))
        else $error("break write not applied");
    a_fcr_direct: assert property (fifo_control_wr && !psel |=> {rx_trigger_sel, dma_mode, fifo_enable} == $past(fbits))
        else $error("direct write not mirrored");
    a_flush_change: assert property (fifo_flush == (fifo_enable != $past(fifo_enable)))
        else $error("flush not tied to enable change");
    a_hit_gated: assert property (!fifo_enable && !$past(fifo_enable) |-> !rx_trigger_hit && !tx_threshold_hit)
        else $error("hit while fifo disabled");
    c_fe_write: cover property (pready && pwrite && paddr == OFS_FIFO_EN_MIRROR);
    c_err: cover property (pready && pslverr);
    c_rx_hit: cover property (rx_trigger_hit && rx_trigger_sel == RX_TRIG_TWO_SHORT);
endmodule // uart_shadow_chk
bind uart_shadow_control_regs uart_shadow_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
    .paddr, .pwdata, .prdata, .fifo_control_wr, .break_ctrl, .dma_mode, .fifo_enable, .fifo_flush,
    .rx_trigger_hit, .tx_threshold_hit, .fifo_control_wdata, .rx_trigger_sel);
`default_nettype wire

//--- tb/test_uart_shadow_control_regs.sv
// Self-checking bench for the shadow control register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t got %h want %h", $time, a, b); end end
module test_uart_shadow_control_regs
    import shadow_regs_pkg::*;
;
    logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0, prdata, r, rd;
    logic              pready, pslverr, break_ctrl, dma_mode, fifo_enable, fifo_flush, er;
    logic              rx_trigger_hit, tx_threshold_hit, line_control_wr = 1'b0, fifo_control_wr = 1'b0;
    logic [7:0]        line_control_wdata = 8'h00, fifo_control_wdata = 8'h00;
    logic [LEVEL_W-1:0] rx_fifo_level = 5'h00, tx_fifo_level = 5'h00;
    logic [TRIG_W-1:0] rx_trigger_sel, tx_trigger_sel;
    logic [7:0]        offs [7] = '{8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0, 8'h8C, 8'hA4};
    int                num_errors = 0, checked = 0, seed = 84;
    int                m_brk = 0, m_fe = 0, m_dma = 0, m_rx = 0, m_tx = 0;

    uart_shadow_control_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .line_control_wr, .line_control_wdata, .fifo_control_wr, .fifo_control_wdata,
        .rx_fifo_level, .tx_fifo_level, .break_ctrl, .dma_mode, .fifo_enable, .rx_trigger_sel,
        .tx_trigger_sel, .fifo_flush, .rx_trigger_hit, .tx_threshold_hit);

    initial forever #10 pclk = ~pclk;

    function automatic logic mapped(input logic [7:0] a);
        return a inside {8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0};
    endfunction

    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h90: return 32'(m_brk);
            8'h94: return 32'(m_dma);
            8'h98: return 32'(m_fe);
            8'h9C: return 32'(m_rx);
            8'hA0: return 32'(m_tx);
            default: return 32'h0;
        endcase
    endfunction

    // Outputs are checked one edge after release, once the write has landed
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic f0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        f0 = m_fe[0];
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(er, !mapped(a))
        if (!w) `CHK(rd, exp_rd(a))
        else if (a == 8'h90) m_brk = d[0];
        else if (a == 8'h94) m_dma = d[0];
        else if (a == 8'h98) m_fe = d[0];
        else if (a == 8'h9C) m_rx = d[1:0];
        else if (a == 8'hA0) m_tx = d[1:0];
        @(posedge pclk);
        `CHK({break_ctrl, dma_mode, fifo_enable, rx_trigger_sel, tx_trigger_sel}, 7'({m_brk[0], m_dma[0], m_fe[0], m_rx[1:0], m_tx[1:0]}))
        `CHK(fifo_flush, 1'(m_fe[0] != f0))
    endtask

    task direct(input logic [7:0] l, input logic [7:0] f);
        logic f0;
        line_control_wr <= 1'b1; line_control_wdata <= l; fifo_control_wr <= 1'b1; fifo_control_wdata <= f;
        f0 = m_fe[0];
        @(posedge pclk);
        line_control_wr <= 1'b0;
        fifo_control_wr <= 1'b0;
        m_brk = l[6]; m_fe = f[0]; m_dma = f[3]; m_rx = f[7:6]; m_tx = f[5:4];
        @(posedge pclk);
        `CHK(fifo_flush, 1'(f[0] != f0))
    endtask

    task hits(input int rl, input int tl);
        rx_fifo_level <= 5'(rl);
        tx_fifo_level <= 5'(tl);
        repeat (2) @(posedge pclk);
        `CHK(rx_trigger_hit, 1'(m_fe[0] && rl >= (m_rx == 0 ? 1 : m_rx == 3 ? 14 : 4 * m_rx)))
        `CHK(tx_threshold_hit, 1'(m_fe[0] && (m_tx == 0 ? tl == 0 : tl <= (1 << m_tx))))
    endtask

    task test_done;
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) apb(1'b0, offs[i], 32'h0);
        repeat (60)
        begin
            r = $random(seed);
            apb(r[0], offs[r[3:1] % 7], $random(seed));
        end
        repeat (8)
        begin
            r = $random(seed);
            direct(r[7:0], r[15:8]);
            foreach (offs[i]) apb(1'b0, offs[i], 32'h0);
        end
        // Every trigger code, with the fifo both off and on
        for (int c = 0; c < 32; c++)
        begin
            apb(1'b1, OFS_RX_TRIG_MIRROR, 32'(c[1:0]));
            apb(1'b1, OFS_TX_TRIG_MIRROR, 32'(c[3:2]));
            apb(1'b1, OFS_FIFO_EN_MIRROR, 32'(c[4]));
            repeat (6)
            begin
                r = $random(seed);
                hits(r[7:0] % 17, r[15:8] % 17);
            end
        end
        test_done;
    end

    initial
    begin
        repeat (30000) @(posedge pclk);
        num_errors++;
        test_done;
    end
endmodule // test_uart_shadow_control_regs
`default_nettype wire
